// ===== verilog/cps_device.sv
// device end: scan port, configuration arrays, security bit, boundary cells
// runs wholly on the link tck; user-side ports are in that domain too
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_device
  import cps_pkg::*;
(
  cps_link_if.dev                  link,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [`CPS_BS_W-1:0]   pin_in,
  input  wire logic [`CPS_BS_W-1:0]   core_out,
  input  wire logic [`CPS_ADDR_W-1:0] user_addr,
  output logic [`CPS_DATA_W-1:0]      user_rdata,
  output logic                        ready,
  output logic                        secured,
  output logic [`CPS_DATA_W-1:0]      io_cfg,
  output logic [`CPS_BS_W-1:0]        pin_out
);
  cps_dev_s                    q;
  cps_dev_s                    d;
  logic [`CPS_DATA_W-1:0]      nv_mem  [`CPS_WORDS];
  logic [`CPS_DATA_W-1:0]      vol_mem [`CPS_WORDS];
  logic                        nv_we;
  logic                        nv_erase;
  logic                        vol_we;
  logic [`CPS_ADDR_W-1:0]      vol_waddr;
  logic [`CPS_DATA_W-1:0]      vol_wdata;
  logic                        boot_copy;
  logic [3:0]                  len;
  logic                        tms;

  assign tms = link.tms;

  function automatic logic [3:0] dr_len(input logic [`CPS_IR_W-1:0] ir);
    logic [3:0] l;
    l = `CPS_LEN_BYPASS;
    if (ir == `CPS_IR_EXTEST || ir == `CPS_IR_SAMPLE) begin
      l = `CPS_LEN_BSCAN;
    end else if (ir == `CPS_IR_PROG_NV || ir == `CPS_IR_PROG_VOL || ir == `CPS_IR_READ ||
                 ir == `CPS_IR_IO_QUICK) begin
      l = `CPS_LEN_CONFIG;
    end
    return l;
  endfunction

  always_comb begin
    d         = q;
    nv_we     = 1'b0;
    nv_erase  = 1'b0;
    vol_we    = 1'b0;
    vol_waddr = q.dr[`CPS_DR_ADDR_LSB +: `CPS_ADDR_W];
    vol_wdata = q.dr[`CPS_DR_DATA_LSB +: `CPS_DATA_W];
    boot_copy = 1'b0;
    len       = dr_len(q.ir);

    // pins come from outside the domain: three stages, change once two agree
    d.p1 = pin_in;
    d.p2 = q.p1;
    d.p3 = q.p2;
    if (q.p2 == q.p3) begin
      d.pf = q.p3;
    end

    // standard controller state walk
    unique case (q.tap)
      TAP_RESET:  d.tap = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   d.tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: d.tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: d.tap = tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_SHF_DR: d.tap = tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_EX1_DR: d.tap = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: d.tap = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: d.tap = tms ? TAP_UPD_DR : TAP_SHF_DR;
      TAP_UPD_DR: d.tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: d.tap = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: d.tap = tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_SHF_IR: d.tap = tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_EX1_IR: d.tap = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: d.tap = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: d.tap = tms ? TAP_UPD_IR : TAP_SHF_IR;
      TAP_UPD_IR: d.tap = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase

    unique case (q.tap)
      TAP_RESET: begin
        d.ir = `CPS_IR_BYPASS;
      end
      TAP_CAP_IR: begin
        d.irs = `CPS_IR_CAPTURE;
      end
      TAP_SHF_IR: begin
        d.irs = {link.tdi, q.irs[`CPS_IR_W-1:1]};
      end
      TAP_UPD_IR: begin
        d.ir = q.irs;
      end
      TAP_CAP_DR: begin
        d.dr = '0;
        if (q.ir == `CPS_IR_EXTEST || q.ir == `CPS_IR_SAMPLE) begin
          d.dr[`CPS_BS_W-1:0] = q.pf;
        end else if (q.ir == `CPS_IR_READ) begin
          d.dr[`CPS_DR_ADDR_LSB +: `CPS_ADDR_W] = q.addr;
          // secure part answers a fixed pattern, never array content
          d.dr[`CPS_DR_DATA_LSB +: `CPS_DATA_W] = q.sec ? `CPS_BLOCKED_WORD : nv_mem[q.addr];
        end
      end
      TAP_SHF_DR: begin
        // length follows the instruction so chained parts see the right delay
        d.dr = q.dr >> 1;
        d.dr[len - 4'h1] = link.tdi;
      end
      TAP_UPD_DR: begin
        unique case (q.ir)
          `CPS_IR_EXTEST: d.bs_upd = q.dr[`CPS_BS_W-1:0];
          `CPS_IR_PROG_NV: nv_we = !q.sec;
          `CPS_IR_PROG_VOL: vol_we = !q.sec;
          `CPS_IR_READ: d.addr = q.dr[`CPS_DR_ADDR_LSB +: `CPS_ADDR_W];
          `CPS_IR_ERASE_ALL: begin
            nv_erase = 1'b1;
            d.sec    = 1'b0;
          end
          `CPS_IR_SET_SEC: d.sec = 1'b1;
          `CPS_IR_IO_QUICK: d.io_cfg = q.dr[`CPS_DR_DATA_LSB +: `CPS_DATA_W];
          default: d.addr = q.addr;
        endcase
      end
      default: d.tap = d.tap;
    endcase

    d.tdo = (d.tap == TAP_SHF_IR) ? d.irs[0] : d.dr[0];

    // parallel host port; a scan write in the same edge takes the slot
    if (link.mp_we && !vol_we) begin
      vol_we    = 1'b1;
      vol_waddr = link.mp_addr;
      vol_wdata = link.mp_data;
    end

    if (q.boot) begin
      boot_copy = 1'b1;
      d.boot    = 1'b0;
      d.ready   = 1'b1;
    end

    d.pin_out = (q.ir == `CPS_IR_EXTEST) ? q.bs_upd : core_out;
    d.rdata   = vol_mem[user_addr];
  end

  always_ff @(posedge link.tck) begin
    if (rst) begin
      q      <= '0;
      q.ir   <= `CPS_IR_BYPASS;
      // non-volatile like the array: kept over reset, unknown until the first erase or set-security command
      q.sec  <= q.sec;
      q.boot <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // arrays hold no reset: the non-volatile one must survive it
  always_ff @(posedge link.tck) begin
    if (ce) begin
      if (nv_erase) begin
        for (int i = 0; i < `CPS_WORDS; i++) begin
          nv_mem[i] <= `CPS_ERASED_WORD;
        end
      end else if (nv_we) begin
        nv_mem[q.dr[`CPS_DR_ADDR_LSB +: `CPS_ADDR_W]] <= q.dr[`CPS_DR_DATA_LSB +: `CPS_DATA_W];
      end
    end
  end

  always_ff @(posedge link.tck) begin
    if (ce) begin
      if (boot_copy) begin
        vol_mem <= nv_mem;
      end else if (vol_we) begin
        vol_mem[vol_waddr] <= vol_wdata;
      end
    end
  end

  assign link.tdo   = q.tdo;
  assign user_rdata = q.rdata;
  assign ready      = q.ready;
  assign secured    = q.sec;
  assign io_cfg     = q.io_cfg;
  assign pin_out    = q.pin_out;
endmodule

// ===== verilog/cps_consts.svh
// constants of the configuration, programming and security block
// included by cps_pkg and by both ends; definitions only
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

`define CPS_IR_W          4
`define CPS_DR_W          12
`define CPS_BS_W          8
`define CPS_ADDR_W        4
`define CPS_DATA_W        8
`define CPS_WORDS         16

// instruction codes
`define CPS_IR_EXTEST     4'h0
`define CPS_IR_SAMPLE     4'h1
`define CPS_IR_PROG_NV    4'h4
`define CPS_IR_PROG_VOL   4'h5
`define CPS_IR_READ       4'h6
`define CPS_IR_ERASE_ALL  4'h7
`define CPS_IR_SET_SEC    4'h9
`define CPS_IR_IO_QUICK   4'hA
`define CPS_IR_BYPASS     4'hF
`define CPS_IR_CAPTURE    4'h1

// data register field positions: {data, addr}, shifted lsb first
`define CPS_DR_ADDR_LSB   0
`define CPS_DR_DATA_LSB   4
`define CPS_LEN_BYPASS    4'h1
`define CPS_LEN_BSCAN     4'h8
`define CPS_LEN_CONFIG    4'hC

// reset and fixed values
`define CPS_SEC_RESET     1'b0
`define CPS_ERASED_WORD   8'hFF
`define CPS_BLOCKED_WORD  8'h00

// host sequence: 32 scan clocks per command
`define CPS_SEQ_LEN       32
`define CPS_SEQ_LAST      5'h1F
`define CPS_SEQ_TMS       32'h0300_0583
`define CPS_POS_DR_FIRST  5'h0D
`define CPS_POS_DR_LAST   5'h18

// timing
`define CPS_CLK_NS        10
`define CPS_TCK_HALF_NS   40
`define CPS_TCK_HALF      ((`CPS_TCK_HALF_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)

`endif

// ===== verilog/cps_pkg.sv
// types shared by both ends of the configuration link
// assumes cps_consts.svh is on the include path
package cps_pkg;
  `include "cps_consts.svh"

  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SHF_DR  = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PAU_DR  = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UPD_DR  = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'hA,
    TAP_SHF_IR  = 4'hB,
    TAP_EX1_IR  = 4'hC,
    TAP_PAU_IR  = 4'hD,
    TAP_EX2_IR  = 4'hE,
    TAP_UPD_IR  = 4'hF
  } cps_tap_e;

  typedef enum logic [2:0] {
    OP_PROG_NV  = 3'h0,
    OP_PROG_VOL = 3'h1,
    OP_READ     = 3'h2,
    OP_ERASE    = 3'h3,
    OP_SECURE   = 3'h4,
    OP_IO_QUICK = 3'h5,
    OP_EXTEST   = 3'h6,
    OP_MP_LOAD  = 3'h7
  } cps_op_e;

  typedef struct packed {
    cps_tap_e                  tap;
    logic [`CPS_IR_W-1:0]      ir;
    logic [`CPS_IR_W-1:0]      irs;
    logic [`CPS_DR_W-1:0]      dr;
    logic                      tdo;
    logic [`CPS_ADDR_W-1:0]    addr;
    logic                      sec;
    logic [`CPS_DATA_W-1:0]    io_cfg;
    logic [`CPS_BS_W-1:0]      bs_upd;
    logic [`CPS_BS_W-1:0]      p1;
    logic [`CPS_BS_W-1:0]      p2;
    logic [`CPS_BS_W-1:0]      p3;
    logic [`CPS_BS_W-1:0]      pf;
    logic [`CPS_BS_W-1:0]      pin_out;
    logic                      boot;
    logic                      ready;
    logic [`CPS_DATA_W-1:0]    rdata;
  } cps_dev_s;

  typedef struct packed {
    logic [2:0]                div;
    logic                      busy;
    logic [4:0]                pos;
    cps_op_e                   op;
    logic [`CPS_SEQ_LEN-1:0]   tdi_seq;
    logic                      tck;
    logic                      tms;
    logic                      tdi;
    logic                      mp_we;
    logic [`CPS_ADDR_W-1:0]    mp_addr;
    logic [`CPS_DATA_W-1:0]    mp_data;
    logic                      s1;
    logic                      s2;
    logic                      s3;
    logic                      tdo_f;
    logic [`CPS_DR_W-1:0]      cap;
    logic [`CPS_DR_W-1:0]      rdata;
    logic                      done;
    logic                      ready;
  } cps_host_s;
endpackage

// ===== verilog/cps_link_if.sv
// scan link plus microprocessor_config_port between programmer and device
// the host end makes tck; both ends sample on its rising edge
`timescale 1ns/1ps
`include "cps_consts.svh"
interface cps_link_if;
  import cps_pkg::*;
  logic                      tck;
  logic                      tms;
  logic                      tdi;
  logic                      tdo;
  logic                      mp_we;
  logic [`CPS_ADDR_W-1:0]    mp_addr;
  logic [`CPS_DATA_W-1:0]    mp_data;

  modport dev  (input tck, tms, tdi, mp_we, mp_addr, mp_data, output tdo);
  modport host (output tck, tms, tdi, mp_we, mp_addr, mp_data, input tdo);
endinterface

// ===== verilog/cps_host.sv
// programmer end: makes tck by dividing clock, plays a fixed 32-edge scan
// sequence per command; tdo crosses back through three stages
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_host
  import cps_pkg::*;
(
  cps_link_if.host                     link,
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    cmd_valid,
  input  wire cps_op_e                 cmd_op,
  input  wire logic [`CPS_ADDR_W-1:0]  cmd_addr,
  input  wire logic [`CPS_DATA_W-1:0]  cmd_data,
  output logic                         cmd_ready,
  output logic                         done,
  output logic [`CPS_DR_W-1:0]         rdata
);
  localparam logic [2:0] DIV_RISE = 3'(`CPS_TCK_HALF - 1);
  localparam logic [2:0] DIV_LAST = 3'(2 * `CPS_TCK_HALF - 1);
  localparam logic [`CPS_SEQ_LEN-1:0] SEQ_TMS = `CPS_SEQ_TMS;

  cps_host_s                   q;
  cps_host_s                   d;
  logic                        wrap;
  logic [`CPS_IR_W-1:0]        instr;

  function automatic logic [`CPS_IR_W-1:0] op_instr(input cps_op_e op);
    logic [`CPS_IR_W-1:0] r;
    unique case (op)
      OP_PROG_NV:  r = `CPS_IR_PROG_NV;
      OP_PROG_VOL: r = `CPS_IR_PROG_VOL;
      OP_READ:     r = `CPS_IR_READ;
      OP_ERASE:    r = `CPS_IR_ERASE_ALL;
      OP_SECURE:   r = `CPS_IR_SET_SEC;
      OP_IO_QUICK: r = `CPS_IR_IO_QUICK;
      OP_EXTEST:   r = `CPS_IR_EXTEST;
      OP_MP_LOAD:  r = `CPS_IR_BYPASS;
    endcase
    return r;
  endfunction

  always_comb begin
    d      = q;
    wrap   = (q.div == DIV_LAST);
    instr  = op_instr(cmd_op);
    d.done = 1'b0;
    d.div  = wrap ? 3'h0 : q.div + 3'h1;
    d.tck  = (d.div > DIV_RISE);

    d.s1 = link.tdo;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.tdo_f = q.s3;
    end

    // sample just before the rising edge, well after the device moved tdo
    if (q.busy && q.div == DIV_RISE && q.pos >= `CPS_POS_DR_FIRST && q.pos <= `CPS_POS_DR_LAST) begin
      d.cap = {q.tdo_f, q.cap[`CPS_DR_W-1:1]};
    end

    if (wrap) begin
      d.mp_we = 1'b0;
      if (q.ready && cmd_valid) begin
        d.busy    = 1'b1;
        d.pos     = 5'h0;
        d.op      = cmd_op;
        d.tdi_seq = {7'h00, cmd_data, cmd_addr, 5'h00, instr, 4'h0};
        d.mp_we   = (cmd_op == OP_MP_LOAD);
        d.mp_addr = cmd_addr;
        d.mp_data = cmd_data;
      end else if (q.busy) begin
        if (q.pos == `CPS_SEQ_LAST) begin
          d.busy  = 1'b0;
          d.done  = 1'b1;
          d.rdata = q.cap;
        end else begin
          d.pos = q.pos + 5'h1;
        end
      end
    end

    // parallel loads stay in idle: no scan traffic during them
    d.tms = d.busy && (d.op != OP_MP_LOAD) && SEQ_TMS[d.pos];
    d.tdi = d.busy && d.tdi_seq[d.pos];
    d.ready = !d.busy && (d.div == DIV_LAST);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign link.tck     = q.tck;
  assign link.tms     = q.tms;
  assign link.tdi     = q.tdi;
  assign link.mp_we   = q.mp_we;
  assign link.mp_addr = q.mp_addr;
  assign link.mp_data = q.mp_data;
  assign cmd_ready    = q.ready;
  assign done         = q.done;
  assign rdata        = q.rdata;
endmodule

// ===== verif/cps_link_sva.sv
// checker for the scan link and the microprocessor_config_port wires
// instantiated in tb beside cps_link_if; sees plain link signals only
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_link_sva (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   dev_rst,
  input wire logic                   tck,
  input wire logic                   tms,
  input wire logic                   tdi,
  input wire logic                   tdo,
  input wire logic                   mp_we,
  input wire logic [`CPS_ADDR_W-1:0] mp_addr,
  input wire logic [`CPS_DATA_W-1:0] mp_data
);
  a_tck_high_phase : assert property (
    @(posedge clock) disable iff (rst) $rose(tck) |-> tck[*4] ##1 !tck)
    else $error("link clock high phase not four cycles");
  a_tck_low_phase : assert property (
    @(posedge clock) disable iff (rst) $fell(tck) |-> (!tck)[*4] ##1 tck)
    else $error("link clock low phase not four cycles");
  // mode and data move only while tck is low, so the device never samples a moving line
  a_tms_moves_low : assert property (
    @(posedge clock) disable iff (rst) $changed(tms) |-> !tck)
    else $error("mode select changed while link clock high");
  a_tdi_moves_low : assert property (
    @(posedge clock) disable iff (rst) $changed(tdi) |-> !tck)
    else $error("serial data in changed while link clock high");
  a_tdo_after_rise : assert property (
    @(posedge clock) disable iff (rst) $changed(tdo) |-> $rose(tck))
    else $error("serial data out changed away from a link clock rise");
  a_mp_one_rise : assert property (
    @(posedge tck) disable iff (dev_rst) mp_we |=> !mp_we)
    else $error("config port write seen on two link clock rises");
  a_mp_bus_steady : assert property (
    @(posedge clock) disable iff (rst) mp_we && $past(mp_we) |-> $stable(mp_addr) && $stable(mp_data))
    else $error("config port address or data moved during a write");
  // three high mode bits in a row would start walking the chain towards test-logic-reset
  a_tms_short_run : assert property (
    @(posedge tck) disable iff (dev_rst) tms ##1 tms |=> !tms)
    else $error("mode select high on three link clock rises");
  c_mp_write : cover property (@(posedge tck) disable iff (dev_rst) mp_we);
  c_tms_pair : cover property (@(posedge tck) disable iff (dev_rst) tms ##1 tms);
  c_tdo_moves : cover property (@(posedge clock) disable iff (rst) $changed(tdo));
endmodule

// ===== verif/tb.sv
// testbench: host and device joined by cps_link_if, driven from the host command port
// assumes design files and cps_link_sva compiled first; ce tied high
`timescale 1ns/1ps
`include "cps_consts.svh"
module tb;
  import cps_pkg::*;
  logic        clock      = 1'b0;
  logic        rst        = 1'b1;
  logic        dev_rst    = 1'b1;
  logic        ce         = 1'b1;
  logic        cmd_valid  = 1'b0;
  cps_op_e     cmd_op     = OP_READ;
  logic [3:0]  cmd_addr   = 4'h0;
  logic [7:0]  cmd_data   = 8'h00;
  logic [7:0]  pin_in     = 8'h69;
  logic [7:0]  core_out   = 8'hE7;
  logic [3:0]  user_addr  = 4'h0;
  logic        cmd_ready;
  logic        done;
  logic        ready;
  logic        secured;
  logic [11:0] rdata;
  logic [7:0]  user_rdata;
  logic [7:0]  io_cfg;
  logic [7:0]  pin_out;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          cycles     = 0;

  cps_link_if link ();
  cps_host i_cps_host (.link(link.host), .clock(clock), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .rdata(rdata));
  cps_device i_cps_device (.link(link.dev), .rst(dev_rst), .ce(ce), .pin_in(pin_in), .core_out(core_out),
    .user_addr(user_addr), .user_rdata(user_rdata), .ready(ready), .secured(secured), .io_cfg(io_cfg),
    .pin_out(pin_out));
  cps_link_sva i_cps_link_sva (.clock(clock), .rst(rst), .dev_rst(dev_rst), .tck(link.tck), .tms(link.tms),
    .tdi(link.tdi), .tdo(link.tdo), .mp_we(link.mp_we), .mp_addr(link.mp_addr), .mp_data(link.mp_data));

  always #5 clock = ~clock;

  // about twenty commands of some 270 cycles each
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  // one host command; returns at the negedge where done is seen
  task automatic run(input cps_op_e op, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    #1 cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    do begin @(negedge clock); n++; end while (cmd_ready !== 1'b1 && n < 40);
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    n = 0;
    do begin @(negedge clock); n++; end while (done !== 1'b1 && n < 400);
    cmp_bit(done, 1'b1);
  endtask

  // capture address is set by the first read, the word comes with the second
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    run(OP_READ, a, 8'h00);
    run(OP_READ, a, 8'h00);
    cmp_byte(rdata[11:4], exp);
    cmp_byte({4'h0, rdata[3:0]}, {4'h0, a});
  endtask

  task automatic peek(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1 user_addr = a;
    repeat (3) @(posedge link.tck);
    @(negedge clock);
    cmp_byte(user_rdata, exp);
  endtask

  // device reset while the host idles; boot copy must follow the release
  task automatic dev_reset();
    @(posedge clock);
    #1 dev_rst = 1'b1;
    repeat (3) @(posedge link.tck);
    @(negedge clock);
    cmp_bit(ready, 1'b0);
    @(posedge clock);
    #1 dev_rst = 1'b0;
    repeat (3) @(posedge link.tck);
    @(negedge clock);
    cmp_bit(ready, 1'b1);
  endtask

  task automatic t_erase_prog();
    run(OP_ERASE, 4'h0, 8'h00);
    cmp_bit(secured, 1'b0);
    rd(4'h2, 8'hFF);
    run(OP_PROG_NV, 4'h3, 8'h5A);
    rd(4'h3, 8'h5A);
    run(OP_PROG_VOL, 4'h5, 8'hC3);
    peek(4'h5, 8'hC3);
    run(OP_MP_LOAD, 4'h6, 8'h96);
    peek(4'h6, 8'h96);
  endtask

  task automatic t_scan_io();
    run(OP_EXTEST, 4'hB, 8'h3C);
    cmp_byte(pin_out, 8'h3C);
    cmp_byte(rdata[7:0], pin_in);
    cmp_byte({4'h0, rdata[11:8]}, 8'h0B);
    run(OP_IO_QUICK, 4'h0, 8'hA5);
    cmp_byte(io_cfg, 8'hA5);
    cmp_byte(pin_out, core_out);
  endtask

  task automatic t_secure();
    run(OP_SECURE, 4'h0, 8'h00);
    cmp_bit(secured, 1'b1);
    rd(4'h3, 8'h00);
    run(OP_PROG_VOL, 4'h5, 8'h22);
    peek(4'h5, 8'hC3);
    run(OP_PROG_NV, 4'h3, 8'h11);
    run(OP_MP_LOAD, 4'h6, 8'h4B);
    peek(4'h6, 8'h4B);
    dev_reset();
    cmp_bit(secured, 1'b1);
    peek(4'h3, 8'h5A);
    run(OP_ERASE, 4'h0, 8'h00);
    cmp_bit(secured, 1'b0);
    rd(4'h3, 8'hFF);
  endtask

  task automatic t_boot();
    run(OP_PROG_NV, 4'h3, 8'h5A);
    dev_reset();
    peek(4'h3, 8'h5A);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    // device reset is sampled on tck, so hold it while tck runs
    repeat (3) @(posedge link.tck);
    @(posedge clock);
    #1 dev_rst = 1'b0;
    repeat (3) @(posedge link.tck);
    @(negedge clock);
    cmp_bit(ready, 1'b1);
    t_erase_prog();
    t_scan_io();
    t_secure();
    t_boot();
    complete_run();
  end
endmodule
